/* src/cmd_handler_consts.svh */
// Opcodes, reply codes, register offsets and reset values of the command handler.
// Included by every design file that decodes commands or registers.
`ifndef CMD_HANDLER_CONSTS_SVH
`define CMD_HANDLER_CONSTS_SVH
`define OP_UF_FIRST      8'h40
`define OP_UF_LAST       8'h47
`define OP_POS_REQ       8'h8A
`define OP_STOP_APP      8'h80
`define OP_RUN_APP       8'h81
`define OP_STEP_APP      8'h82
`define OP_RESET_APP     8'h83
`define OP_DL_ENTER      8'h84
`define OP_DL_EXIT       8'h85
`define OP_MEM_READ      8'h86
`define OP_APP_STATUS    8'h87
`define OP_FW_VERSION    8'h88
`define OP_FACTORY       8'h89
`define OP_SW_RESET      8'hFF
`define ST_OK            8'h64
`define ST_POS_REACHED   8'h80
`define ST_BAD_TYPE      8'h03
`define ST_BAD_VALUE     8'h04
`define MAGIC_VALUE      32'h0000_04D2
`define REG_UF_VALUE     8'h00
`define REG_STATUS       8'h04
`define REG_ACCU         8'h08
`define REG_XREG         8'h0C
`define REG_PC           8'h10
`define RST_WORD         32'h0000_0000
`endif

/* src/cmd_handler_pkg.sv */
// Types shared by the command handler and its helpers.
// Assumes the host framing logic delivers decoded 7-byte commands.
package cmd_handler_pkg;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  ctype;
    logic [7:0]  motor;
    logic [31:0] value;
  } cmd_t;
  typedef struct packed {
    logic        special;
    logic [7:0]  status;
    logic [7:0]  command;
    logic [7:0]  aux;
    logic [31:0] value;
  } reply_t;
  typedef enum logic [1:0] {
    PROG_STOP = 2'b00,
    PROG_RUN  = 2'b01,
    PROG_STEP = 2'b10
  } prog_state_t;
endpackage

/* src/prog_store.sv */
// Program memory holding downloaded commands, one entry per command.
// Assumes writes and reads come from the handler on the same clock.
`timescale 1ns/1ps
module prog_store #(
  parameter int AW = 8
) (
  input  wire logic                  clk,
  input  wire logic                  we,
  input  wire logic [AW-1:0]         waddr,
  input  wire cmd_handler_pkg::cmd_t wdata,
  input  wire logic [AW-1:0]         raddr,
  output cmd_handler_pkg::cmd_t      rdata
);
  cmd_handler_pkg::cmd_t mem [0:(1<<AW)-1];

  // Combinational read so a memory read answers with the same latency as any command
  assign rdata = mem[raddr];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
endmodule // prog_store

/* src/pos_event.sv */
// Per-motor tracking of position-reached requests and pending event replies.
// Assumes start and reached strobes come from motion logic on the same clock.
`timescale 1ns/1ps
module pos_event #(
  parameter int N = 6
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         req,
  input  wire logic         persist,
  input  wire logic [N-1:0] req_mask,
  input  wire logic [N-1:0] mvp_start,
  input  wire logic [N-1:0] reached,
  input  wire logic [N-1:0] ack,
  output logic      [N-1:0] pend
);
  for (genvar i = 0; i < N; i++)
  begin : g_motor
    logic armed_q, armed_d, keep_q, keep_d, track_q, track_d, pend_q, pend_d;

    always_comb
    begin
      armed_d = armed_q;
      keep_d  = keep_q;
      track_d = track_q;
      pend_d  = pend_q;
      // Clear first so a new start in the arrival cycle stays tracked
      if (reached[i] && track_q)
      begin
        track_d = 1'b0;
      end
      if (req)
      begin
        armed_d = req_mask[i];
        keep_d  = persist;
      end
      else if (mvp_start[i] && armed_q)
      begin
        track_d = 1'b1;
        armed_d = keep_q;
      end
      // Set beats an acknowledge arriving in the same cycle
      if (ack[i])
      begin
        pend_d = 1'b0;
      end
      if (reached[i] && track_q)
      begin
        pend_d = 1'b1;
      end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        armed_q <= 1'b0;
        keep_q  <= 1'b0;
        track_q <= 1'b0;
        pend_q  <= 1'b0;
      end
      else
      begin
        armed_q <= armed_d;
        keep_q  <= keep_d;
        track_q <= track_d;
        pend_q  <= pend_d;
      end
    end
    assign pend[i] = pend_q;

    property p_oneshot;
      @(posedge clk) disable iff (!arst_n)
      !req && armed_q && !keep_q && mvp_start[i] |=> !armed_q && track_q;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot request stayed armed");
    property p_persist;
      @(posedge clk) disable iff (!arst_n)
      !req && armed_q && keep_q && mvp_start[i] |=> armed_q && track_q;
    endproperty
    a_persist: assert property (p_persist) else $error("persistent request disarmed");
    property p_mask;
      @(posedge clk) disable iff (!arst_n)
      req |=> armed_q == $past(req_mask[i]);
    endproperty
    a_mask: assert property (p_mask) else $error("motor mask bit not taken");
  end
endmodule // pos_event

/* src/cmd_handler.sv */
// Command interpreter for direct-mode host commands of a multi-axis controller.
// Assumes framing and checksum are handled upstream; all inputs share clk.
// Behaviour
// - Opcodes 64..71 are user functions; reply OK with a user-defined value.
// - Position-reached request replies at once and again when a motor arrives.
// - Request value is a motor mask; bit n selects motor n.
// - Type 0 reports only the first following move-to-position.
// - Type 1 reports every following move-to-position.
// - Immediate reply: status 64h, command 8Ah, byte 0 mask, rest zero.
// - Arrival reply: status 80h, command 8Ah, byte 0 mask, rest zero.
// - Control commands are taken only from the direct-mode host port.
// - Opcode 128 stops the running program.
// - Opcode 129 runs: type 0 from current address, type 1 from value.
// - Opcode 130 executes exactly one instruction, then halts.
// - Opcode 131 stops and clears counter, stack, accumulator, X and flags.
// - Opcode 132 enters download; commands outside the control set are stored, not executed.
// - Opcode 133 leaves download; commands execute normally again.
// - Opcode 134 returns the addressed program memory entry, special format.
// - Opcode 135 returns mode/wait/pointer, mode/wait/pc, accumulator or X.
// - Opcode 136 returns firmware version, string or binary by type.
// - Opcode 137 with value 1234 restores factory settings, no reply.
// - Opcode 255 with value 1234 restarts the processor.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "cmd_handler_consts.svh"
module cmd_handler #(
  parameter int          N_MOTORS  = 6,
  parameter int          AW        = 8,
  parameter logic [31:0] FW_BINARY = 32'h0000_0101, // arbitrary value
  parameter logic [31:0] FW_STRING = 32'h5844_3031  // arbitrary value
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    cmd_valid,
  input  wire cmd_handler_pkg::cmd_t   cmd,
  output cmd_handler_pkg::reply_t      reply,
  output logic                         reply_valid,
  output cmd_handler_pkg::cmd_t        fwd,
  output logic                         fwd_valid,
  input  wire logic [N_MOTORS-1:0]     mvp_start,
  input  wire logic [N_MOTORS-1:0]     pos_reached,
  input  wire logic                    instr_done,
  input  wire logic                    wait_flag,
  output logic                         prog_run,
  output logic                         prog_step,
  output logic [AW-1:0]                prog_pc,
  output logic                         app_clear,
  output logic                         factory_restore,
  output logic                         cpu_reset,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata
);
  cmd_handler_pkg::prog_state_t state_q, state_d;
  cmd_handler_pkg::reply_t      reply_q, reply_d;
  cmd_handler_pkg::cmd_t        fwd_q, fwd_d, mem_rdata;
  logic [AW-1:0]       pc_q, pc_d, dl_ptr_q, dl_ptr_d;
  logic [31:0]         accu_q, accu_d, x_q, x_d, uf_q, uf_d, rdata_q, rdata_d;
  logic                dl_q, dl_d, rvalid_q, rvalid_d, fvalid_q, fvalid_d;
  logic                run_q, run_d, step_q, step_d, clr_q, clr_d;
  logic                fact_q, fact_d, cpurst_q, cpurst_d;
  logic                is_ctrl, mem_we, pos_req;
  logic [N_MOTORS-1:0] pend, ack;
  logic [7:0]          pend_byte;

  // Control set is recognised only here, on the host port
  assign is_ctrl = (cmd.opcode >= `OP_STOP_APP && cmd.opcode <= `OP_FACTORY)
                 || cmd.opcode == `OP_SW_RESET;
  assign mem_we  = cmd_valid && dl_q && !is_ctrl;
  assign pos_req = cmd_valid && !dl_q && cmd.opcode == `OP_POS_REQ;
  assign pend_byte = 8'(pend);

  prog_store #(
    .AW (AW)
  ) u_store (
    .clk   (clk),
    .we    (mem_we),
    .waddr (dl_ptr_q),
    .wdata (cmd),
    .raddr (cmd.value[AW-1:0]),
    .rdata (mem_rdata)
  );

  pos_event #(
    .N (N_MOTORS)
  ) u_pos (
    .clk       (clk),
    .arst_n    (arst_n),
    .req       (pos_req),
    .persist   (cmd.ctype[0]),
    .req_mask  (cmd.value[N_MOTORS-1:0]),
    .mvp_start (mvp_start),
    .reached   (pos_reached),
    .ack       (ack),
    .pend      (pend)
  );

  always_comb
  begin
    state_d  = state_q;
    pc_d     = pc_q;
    dl_d     = dl_q;
    dl_ptr_d = dl_ptr_q;
    accu_d   = accu_q;
    x_d      = x_q;
    uf_d     = uf_q;
    reply_d  = '0;
    rvalid_d = 1'b0;
    fwd_d    = fwd_q;
    fvalid_d = 1'b0;
    step_d   = 1'b0;
    clr_d    = 1'b0;
    fact_d   = 1'b0;
    cpurst_d = 1'b0;
    ack      = '0;
    // Program engine progress
    if (instr_done && state_q != cmd_handler_pkg::PROG_STOP)
    begin
      pc_d = pc_q + 1'b1;
      if (state_q == cmd_handler_pkg::PROG_STEP)
      begin
        state_d = cmd_handler_pkg::PROG_STOP;
      end
    end
    // Bus writes; a same-cycle command below takes precedence
    if (reg_wr)
    begin
      unique case (reg_addr)
        `REG_UF_VALUE: uf_d   = reg_wdata;
        `REG_ACCU:     accu_d = reg_wdata;
        `REG_XREG:     x_d    = reg_wdata;
        default:       ;
      endcase
    end
    if (cmd_valid)
    begin
      rvalid_d        = 1'b1;
      reply_d.status  = `ST_OK;
      reply_d.command = cmd.opcode;
      if (mem_we)
      begin
        dl_ptr_d = dl_ptr_q + 1'b1;
        rvalid_d = 1'b0;
      end
      else if (cmd.opcode >= `OP_UF_FIRST && cmd.opcode <= `OP_UF_LAST)
      begin
        reply_d.value = uf_q;
      end
      else if (cmd.opcode == `OP_POS_REQ)
      begin
        reply_d.value = {24'h00_0000, cmd.value[7:0]};
      end
      else
      begin
        unique case (cmd.opcode)
          `OP_STOP_APP: state_d = cmd_handler_pkg::PROG_STOP;
          `OP_RUN_APP:
          begin
            state_d = cmd_handler_pkg::PROG_RUN;
            if (cmd.ctype[0])
            begin
              pc_d = cmd.value[AW-1:0];
            end
          end
          `OP_STEP_APP:
          begin
            state_d = cmd_handler_pkg::PROG_STEP;
            step_d  = 1'b1;
          end
          `OP_RESET_APP:
          begin
            state_d = cmd_handler_pkg::PROG_STOP;
            pc_d    = '0;
            accu_d  = `RST_WORD;
            x_d     = `RST_WORD;
            clr_d   = 1'b1;
          end
          `OP_DL_ENTER:
          begin
            dl_d     = 1'b1;
            dl_ptr_d = cmd.value[AW-1:0];
          end
          `OP_DL_EXIT: dl_d = 1'b0;
          `OP_MEM_READ:
          begin
            reply_d.special = 1'b1;
            reply_d.status  = mem_rdata.opcode;
            reply_d.command = mem_rdata.ctype;
            reply_d.aux     = mem_rdata.motor;
            reply_d.value   = mem_rdata.value;
          end
          `OP_APP_STATUS:
          begin
            unique case (cmd.ctype)
              8'h00: reply_d.value = {6'h00, dl_q ? 2'h2 : 2'(state_q), 7'h00,
                                      wait_flag, 16'(dl_ptr_q)};
              8'h01: reply_d.value = {6'h00, dl_q ? 2'h2 : 2'(state_q), 7'h00,
                                      wait_flag, 16'(pc_q)};
              8'h02: reply_d.value = accu_q;
              8'h03: reply_d.value = x_q;
              default: reply_d.status = `ST_BAD_TYPE;
            endcase
          end
          `OP_FW_VERSION:
          begin
            reply_d.special = !cmd.ctype[0];
            reply_d.value   = cmd.ctype[0] ? FW_BINARY : FW_STRING;
          end
          `OP_FACTORY:
          begin
            if (cmd.value == `MAGIC_VALUE)
            begin
              fact_d   = 1'b1;
              rvalid_d = 1'b0;
            end
            else
            begin
              reply_d.status = `ST_BAD_VALUE;
            end
          end
          `OP_SW_RESET:
          begin
            if (cmd.value == `MAGIC_VALUE)
            begin
              cpurst_d = 1'b1;
            end
            else
            begin
              reply_d.status = `ST_BAD_VALUE;
            end
          end
          default:
          begin
            // Everything else belongs to the executing logic downstream
            rvalid_d = 1'b0;
            fvalid_d = 1'b1;
            fwd_d    = cmd;
          end
        endcase
      end
    end
    else if (pend != '0)
    begin
      // Arrival replies use only free reply slots
      rvalid_d        = 1'b1;
      reply_d.status  = `ST_POS_REACHED;
      reply_d.command = `OP_POS_REQ;
      reply_d.value   = {24'h00_0000, pend_byte};
      ack             = pend;
    end
    run_d = state_d != cmd_handler_pkg::PROG_STOP;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q  <= cmd_handler_pkg::PROG_STOP;
      pc_q     <= '0;
      dl_q     <= 1'b0;
      dl_ptr_q <= '0;
      accu_q   <= `RST_WORD;
      x_q      <= `RST_WORD;
      uf_q     <= `RST_WORD;
      reply_q  <= '0;
      rvalid_q <= 1'b0;
      fwd_q    <= '0;
      fvalid_q <= 1'b0;
      run_q    <= 1'b0;
      step_q   <= 1'b0;
      clr_q    <= 1'b0;
      fact_q   <= 1'b0;
      cpurst_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      pc_q     <= pc_d;
      dl_q     <= dl_d;
      dl_ptr_q <= dl_ptr_d;
      accu_q   <= accu_d;
      x_q      <= x_d;
      uf_q     <= uf_d;
      reply_q  <= reply_d;
      rvalid_q <= rvalid_d;
      fwd_q    <= fwd_d;
      fvalid_q <= fvalid_d;
      run_q    <= run_d;
      step_q   <= step_d;
      clr_q    <= clr_d;
      fact_q   <= fact_d;
      cpurst_q <= cpurst_d;
    end
  end

  // Register read port, data in the following cycle only
  always_comb
  begin
    rdata_d = `RST_WORD;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `REG_UF_VALUE: rdata_d = uf_q;
        `REG_STATUS:   rdata_d = {16'h0000, 8'(pend), 5'h00, dl_q, 2'(state_q)};
        `REG_ACCU:     rdata_d = accu_q;
        `REG_XREG:     rdata_d = x_q;
        `REG_PC:       rdata_d = 32'(pc_q);
        default:       rdata_d = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= `RST_WORD;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reply           = reply_q;
  assign reply_valid     = rvalid_q;
  assign fwd             = fwd_q;
  assign fwd_valid       = fvalid_q;
  assign prog_run        = run_q;
  assign prog_step       = step_q;
  assign prog_pc         = pc_q;
  assign app_clear       = clr_q;
  assign factory_restore = fact_q;
  assign cpu_reset       = cpurst_q;
  assign reg_rdata       = rdata_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_uf;
    cmd_valid && !dl_q && cmd.opcode == `OP_UF_FIRST + 8'h03
    |=> reply_valid && reply.status == `ST_OK && reply.value == $past(uf_q);
  endproperty
  a_uf: assert property (p_uf) else $error("user function reply wrong");
  property p_pos_now;
    pos_req |=> reply_valid && reply.status == `ST_OK && reply.command == `OP_POS_REQ
      && reply.value == {24'h00_0000, $past(cmd.value[7:0])};
  endproperty
  a_pos_now: assert property (p_pos_now) else $error("immediate reply wrong");
  property p_pos_evt;
    !cmd_valid && pend != '0 |=> reply_valid && reply.status == `ST_POS_REACHED
      && reply.value[7:0] == 8'($past(pend));
  endproperty
  a_pos_evt: assert property (p_pos_evt) else $error("arrival reply missing");
  property p_evt_fmt;
    reply_valid && reply.status == `ST_POS_REACHED && !reply.special
    |-> reply.command == `OP_POS_REQ && reply.value[31:8] == 24'h00_0000;
  endproperty
  a_evt_fmt: assert property (p_evt_fmt) else $error("arrival reply format");
  property p_stop;
    cmd_valid && !instr_done && cmd.opcode == `OP_STOP_APP ##1 !cmd_valid
    |=> !prog_run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_run_at;
    cmd_valid && cmd.opcode == `OP_RUN_APP && cmd.ctype == 8'h01
    |=> prog_run && prog_pc == $past(cmd.value[AW-1:0]);
  endproperty
  a_run_at: assert property (p_run_at) else $error("run from address wrong");
  property p_step;
    state_q == cmd_handler_pkg::PROG_STEP && instr_done && !cmd_valid
    |=> state_q == cmd_handler_pkg::PROG_STOP && !prog_run;
  endproperty
  a_step: assert property (p_step) else $error("step did not halt");
  property p_reset_app;
    cmd_valid && cmd.opcode == `OP_RESET_APP
    |=> app_clear && prog_pc == '0 && accu_q == `RST_WORD && x_q == `RST_WORD;
  endproperty
  a_reset_app: assert property (p_reset_app) else $error("reset app incomplete");
  property p_store;
    mem_we |=> !fwd_valid && !reply_valid ##0 dl_ptr_q == $past(dl_ptr_q) + 1'b1;
  endproperty
  a_store: assert property (p_store) else $error("download command executed");
  property p_dl_exit;
    cmd_valid && cmd.opcode == `OP_DL_EXIT |=> !dl_q;
  endproperty
  a_dl_exit: assert property (p_dl_exit) else $error("download not left");
  property p_status;
    cmd_valid && cmd.opcode == `OP_APP_STATUS && cmd.ctype == 8'h03
    |=> reply.value == $past(x_q);
  endproperty
  a_status: assert property (p_status) else $error("status X wrong");
  property p_fw;
    cmd_valid && cmd.opcode == `OP_FW_VERSION && cmd.ctype == 8'h01
    |=> reply.value == FW_BINARY && !reply.special;
  endproperty
  a_fw: assert property (p_fw) else $error("binary version wrong");
  property p_factory;
    cmd_valid && cmd.opcode == `OP_FACTORY && cmd.value == `MAGIC_VALUE
    |=> factory_restore && !reply_valid;
  endproperty
  a_factory: assert property (p_factory) else $error("factory restore wrong");
  property p_cpurst;
    cmd_valid && cmd.opcode == `OP_SW_RESET |=> cpu_reset == ($past(cmd.value) == `MAGIC_VALUE);
  endproperty
  a_cpurst: assert property (p_cpurst) else $error("software reset wrong");
endmodule // cmd_handler

/* test/host_model.sv */
// Host side of the command port: sends one direct-mode command at a time.
// Assumes the caller judges replies; nothing is held between commands.
`timescale 1ns/1ps
module host_model (
  input  wire logic             clk,
  output logic                  cmd_valid,
  output cmd_handler_pkg::cmd_t cmd
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic send(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] val);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, ty, 8'h00, val};
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Stale fields must not look valid
    cmd <= ~cmd;
  endtask
endmodule // host_model

/* test/control_command_handler_test.sv */
// Self-checking bench for the command handler.
// Assumes host_model on the command port; bench drives all other inputs.
`timescale 1ns/1ps
module control_command_handler_test;
  localparam logic [31:0] FWB = 32'h0000_0ABC; // arbitrary value
  localparam logic [31:0] FWS = 32'h3132_3334; // arbitrary value
  logic                    clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    cmd_valid;
  cmd_handler_pkg::cmd_t   cmd;
  cmd_handler_pkg::reply_t reply;
  logic                    reply_valid;
  cmd_handler_pkg::cmd_t   fwd;
  logic                    fwd_valid;
  logic [5:0]              mvp_start = '0;
  logic [5:0]              pos_reached = '0;
  logic                    instr_done = 1'b0;
  logic                    wait_flag = 1'b0;
  logic                    prog_run;
  logic                    prog_step;
  logic [7:0]              prog_pc;
  logic                    app_clear;
  logic                    factory_restore;
  logic                    cpu_reset;
  logic [7:0]              reg_addr = '0;
  logic [31:0]             reg_wdata = '0;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic [31:0]             reg_rdata;
  logic [31:0]             rv;
  int                      errors = 0;
  int                      num_checks = 0;
  always #5 clk = ~clk;
  host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));
  cmd_handler #(.FW_BINARY(FWB), .FW_STRING(FWS)) dut (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd), .reply(reply),
    .reply_valid(reply_valid), .fwd(fwd), .fwd_valid(fwd_valid), .mvp_start(mvp_start),
    .pos_reached(pos_reached), .instr_done(instr_done), .wait_flag(wait_flag),
    .prog_run(prog_run), .prog_step(prog_step), .prog_pc(prog_pc), .app_clear(app_clear),
    .factory_restore(factory_restore), .cpu_reset(cpu_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rep(input string nm, input logic [7:0] st, input logic [7:0] co,
                     input logic [31:0] v);
    chk(nm, {reply_valid, reply.status, reply.command, reply.value}, {1'b1, st, co, v});
  endtask
  task automatic go(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] val);
    host.send(op, ty, val);
    #1;
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [5:0] mv, input logic [5:0] pr, input logic dn);
    @(posedge clk);
    mvp_start <= mv;
    pos_reached <= pr;
    instr_done <= dn;
    @(posedge clk);
    mvp_start <= '0;
    pos_reached <= '0;
    instr_done <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Bounded wait; a missing event reply ends the run
  task automatic arrival(input logic [31:0] mask, input bit want);
    int n;
    n = 0;
    // Step off the launching edge before looking
    #1;
    while (reply_valid !== 1'b1 && n < 6)
    begin
      cyc();
      n++;
    end
    if (want)
      rep("arrival", 8'h80, 8'h8A, mask);
    else
      chk("no arrival", reply_valid, 1'b0);
    if (want && reply_valid !== 1'b1)
      wrap_up();
  endtask
  task automatic t_user();
    wr(8'h00, 32'h0000_BEEF);
    for (int op = 8'h40; op <= 8'h47; op++)
    begin
      go(8'(op), 8'h00, 32'h0);
      rep("user fn", 8'h64, 8'(op), 32'h0000_BEEF);
    end
    rd(8'h7C, rv);
    chk("unmapped", rv, 32'h0);
  endtask
  task automatic t_pos();
    go(8'h8A, 8'h01, 32'h05);
    rep("pos req", 8'h64, 8'h8A, 32'h05);
    pulse(6'h01, 6'h00, 1'b0);
    pulse(6'h00, 6'h01, 1'b0);
    arrival(32'h01, 1'b1);
    pulse(6'h04, 6'h00, 1'b0);
    pulse(6'h00, 6'h04, 1'b0);
    arrival(32'h04, 1'b1);
    pulse(6'h02, 6'h00, 1'b0);
    pulse(6'h00, 6'h02, 1'b0);
    arrival(32'h0, 1'b0);
    go(8'h8A, 8'h00, 32'h01);
    rep("pos once", 8'h64, 8'h8A, 32'h01);
    pulse(6'h01, 6'h00, 1'b0);
    pulse(6'h00, 6'h01, 1'b0);
    arrival(32'h01, 1'b1);
    pulse(6'h01, 6'h00, 1'b0);
    pulse(6'h00, 6'h01, 1'b0);
    arrival(32'h0, 1'b0);
  endtask
  task automatic t_prog();
    @(posedge clk);
    wait_flag <= 1'b1;
    go(8'h81, 8'h01, 32'h0A);
    cyc();
    chk("run", {prog_run, prog_pc}, {1'b1, 8'h0A});
    go(8'h87, 8'h01, 32'h0);
    rep("status pc", 8'h64, 8'h87, 32'h0101_000A);
    go(8'h80, 8'h00, 32'h0);
    cyc();
    chk("stop", prog_run, 1'b0);
    go(8'h81, 8'h00, 32'h0);
    cyc();
    chk("resume", {prog_run, prog_pc}, {1'b1, 8'h0A});
    go(8'h80, 8'h00, 32'h0);
    go(8'h82, 8'h00, 32'h0);
    chk("step", {prog_step, prog_run}, 2'b11);
    pulse(6'h00, 6'h00, 1'b1);
    cyc();
    cyc();
    chk("step end", {prog_run, prog_pc}, {1'b0, 8'h0B});
    wr(8'h08, 32'h0000_00A5);
    wr(8'h0C, 32'h0000_005A);
    go(8'h87, 8'h02, 32'h0);
    rep("accu", 8'h64, 8'h87, 32'hA5);
    go(8'h87, 8'h03, 32'h0);
    rep("xreg", 8'h64, 8'h87, 32'h5A);
    go(8'h87, 8'h09, 32'h0);
    chk("bad type", reply.status, 8'h03);
    go(8'h83, 8'h00, 32'h0);
    chk("clear", app_clear, 1'b1);
    cyc();
    chk("clear pc", {prog_run, prog_pc}, 9'h0);
    rd(8'h08, rv);
    chk("clear accu", rv, 32'h0);
    rd(8'h0C, rv);
    chk("clear x", rv, 32'h0);
  endtask
  task automatic t_dl();
    go(8'h84, 8'h00, 32'h03);
    go(8'h87, 8'h00, 32'h0);
    rep("dl status", 8'h64, 8'h87, 32'h0201_0003);
    go(8'h04, 8'h02, 32'h77);
    chk("dl store", {reply_valid, fwd_valid}, 2'b00);
    go(8'h85, 8'h00, 32'h0);
    go(8'h86, 8'h00, 32'h03);
    chk("mem rd", reply, {1'b1, 8'h04, 8'h02, 8'h00, 32'h77});
    go(8'h04, 8'h02, 32'h77);
    chk("fwd", {fwd_valid, fwd}, {1'b1, 8'h04, 8'h02, 8'h00, 32'h77});
  endtask
  task automatic t_misc();
    go(8'h88, 8'h01, 32'h0);
    chk("fw bin", {reply.special, reply.value}, {1'b0, FWB});
    go(8'h88, 8'h00, 32'h0);
    chk("fw str", {reply.special, reply.value}, {1'b1, FWS});
    go(8'h89, 8'h00, 32'h0000_04D2);
    chk("factory", {factory_restore, reply_valid}, 2'b10);
    go(8'h89, 8'h00, 32'h0000_0005);
    chk("factory bad", {factory_restore, reply_valid, reply.status}, {2'b01, 8'h04});
    go(8'hFF, 8'h00, 32'h0000_04D2);
    chk("sw reset", {cpu_reset, reply_valid, reply.status}, {2'b11, 8'h64});
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("reset", {reply_valid, fwd_valid, prog_run, prog_pc, cpu_reset}, 12'h0);
    t_user();
    t_pos();
    t_prog();
    t_dl();
    t_misc();
    wrap_up();
  end
endmodule // control_command_handler_test
